// ===== rtl/cprs_core_regs.sv
// Programmer-visible register set of the processing core
// How it works
// RL1: Two 8-bit accumulators hold operands and results.
// RL2: Both accumulators together form a 16-bit double accumulator.
// RL3: Indexed address is index register plus 5/9/16-bit constant or accumulator.
// RL4: Stack pointer holds address of the last used stack location.
// RL5: Stack saves context on calls and interrupts, also free storage.
// RL6: Program counter is 16 bits, holds next instruction address.
// RL7: Program counter works as base except in auto increment/decrement forms.
// RL8: Flags register holds five status flags, two masks, stop disable bit.
// RL9: Half carry serves BCD only; N Z V C decide branches.
// RL10: Words are big-endian, high byte at the lower address.
// RL11: Words and instructions may sit at any byte address.
// RL12: Single bytes read and write at every address.
// RL13: Queue guarantees three code bytes at each instruction start.
// RL14: Datapath 16 bits, extended math registers up to 20 bits.
// RL15: Accumulator writes and double accumulator writes stay consistent.
`timescale 1ns/1ps
`include "cprs_params.svh"
module cprs_core_regs
  import cprs_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  // Register write port
  input  wire cprs_dst_t    wr_dst_in,
  input  wire logic [19:0]  wr_data_in,
  // Flag update from the ALU
  input  wire logic         flags_we_in,
  input  wire logic [4:0]   flags_hnzvc_in,
  input  wire logic         ccr_we_in,
  input  wire logic [7:0]   ccr_data_in,
  // Program counter control
  input  wire logic         pc_load_in,
  input  wire logic [15:0]  pc_target_in,
  input  wire logic [1:0]   pc_advance_in,
  // Indexed addressing request
  input  wire cprs_base_t   ix_base_in,
  input  wire cprs_ixmode_t ix_mode_in,
  input  wire logic [15:0]  ix_const_in,
  input  wire logic         ix_update_in,
  // Stack, memory word and memory byte requests
  input  wire logic         push_word_in,
  input  wire logic         pull_word_in,
  input  wire logic [15:0]  word_in,
  input  wire logic         mem_word_start_in,
  input  wire logic         mem_byte_in,
  input  wire logic         mem_we_in,
  input  wire logic [15:0]  mem_addr_in,
  input  wire logic [7:0]   mem_rdata_in,
  // Branch condition query
  input  wire logic [3:0]   br_cond_in,
  // Program byte fill and consumption
  input  wire logic         code_valid_in,
  input  wire logic [7:0]   code_byte_in,
  input  wire logic [1:0]   code_used_in,
  // Register views
  output logic [7:0]        acc_a_out,
  output logic [7:0]        acc_b_out,
  output logic [15:0]       acc_d_out,
  output logic [15:0]       index_x_out,
  output logic [15:0]       index_y_out,
  output logic [15:0]       stack_top_pointer_out,
  output logic [15:0]       pc_out,
  output logic [7:0]        condition_flags_register_out,
  output logic [19:0]       ext_out,
  // Addressing and memory
  output logic [15:0]       ea_out,
  output logic              ix_illegal_out,
  output logic              mem_req_out,
  output logic              mem_wr_out,
  output logic [15:0]       mem_addr_out,
  output logic [7:0]        mem_wdata_out,
  output logic [15:0]       mem_word_out,
  output logic              mem_word_done_out,
  // Branch and queue status
  output logic              br_take_out,
  output logic              instr_ready_out,
  output logic [23:0]       instr_bytes_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic [7:0]  acc_a;
  logic [7:0]  acc_b;
  logic [15:0] index_x;
  logic [15:0] index_y;
  logic [15:0] stack_top_pointer;
  logic [15:0] pc;
  logic [7:0]  condition_flags_register;
  logic [19:0] ext;
  logic [15:0] ix_base;
  logic [15:0] ea;
  logic        ix_illegal;
  logic [15:0] sp_push;
  logic [15:0] next_sp;
  logic [15:0] next_ptr;
  logic        ptr_upd;
  logic        br_take;
  logic [2:0]  q_level;
  logic [23:0] q_head;
  logic        flush;
  cprs_state_t state;
  logic [15:0] word_addr;
  logic        word_wr;
  logic [7:0]  word_hi;
  logic [15:0] word_wdata;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] pick_base(input cprs_base_t sel, input logic [15:0] x,
                                            input logic [15:0] y, input logic [15:0] s,
                                            input logic [15:0] p);
    unique case (sel)
      CPRS_BASE_X:  pick_base = x;
      CPRS_BASE_Y:  pick_base = y;
      CPRS_BASE_SP: pick_base = s;
      default:      pick_base = p;
    endcase
  endfunction : pick_base
  assign ix_base = pick_base(ix_base_in, index_x, index_y, stack_top_pointer, pc);
  cprs_ea_unit u_ea (
    .base_in     (ix_base),
    .base_sel_in (ix_base_in),
    .mode_in     (ix_mode_in),
    .const_in    (ix_const_in),
    .acc_a_in    (acc_a),
    .acc_b_in    (acc_b),
    .ea_out      (ea),
    .illegal_out (ix_illegal)
  );
  // Auto forms update the pointer; pre forms use the new value as address
  assign next_ptr = ea;
  assign ptr_upd  = ix_update_in && (ix_mode_in == CPRS_IX_AUTO) && !ix_illegal;  // RL7
  //////////////////////////////////////////////////////////////////////////////
  // Pre-decrement push keeps the pointer on the last used slot
  assign sp_push = stack_top_pointer - 16'h0002;  // RL4
  always_comb
  begin
    next_sp = stack_top_pointer;
    if (push_word_in)
      next_sp = sp_push;  // RL5
    else if (pull_word_in)
      next_sp = stack_top_pointer + 16'h0002;  // RL5
    else if (wr_dst_in == CPRS_DST_SP)
      next_sp = wr_data_in[15:0];
    else if (ptr_upd && ix_base_in == CPRS_BASE_SP)
      next_sp = next_ptr;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Branch conditions from N Z V C only; half carry never used
  logic n_f, z_f, v_f, c_f;
  assign n_f = condition_flags_register[`CPRS_CCR_N];
  assign z_f = condition_flags_register[`CPRS_CCR_Z];
  assign v_f = condition_flags_register[`CPRS_CCR_V];
  assign c_f = condition_flags_register[`CPRS_CCR_C];
  logic br_raw;
  always_comb
  begin
    unique case (br_cond_in[3:1])
      3'h0:    br_raw = 1'b1;
      3'h1:    br_raw = !(c_f | z_f);
      3'h2:    br_raw = !c_f;
      3'h3:    br_raw = !z_f;
      3'h4:    br_raw = !v_f;
      3'h5:    br_raw = !n_f;
      3'h6:    br_raw = !(n_f ^ v_f);
      default: br_raw = !(z_f | (n_f ^ v_f));
    endcase
  end
  assign br_take = br_raw ^ br_cond_in[0];  // RL9
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      acc_a   <= 8'h00;
      acc_b   <= 8'h00;
      index_x <= 16'h0000;
      index_y <= 16'h0000;
      ext     <= 20'h00000;
    end
    else
    begin
      if (wr_dst_in == CPRS_DST_A || wr_dst_in == CPRS_DST_D)
        acc_a <= (wr_dst_in == CPRS_DST_D) ? wr_data_in[15:8] : wr_data_in[7:0];  // RL15
      if (wr_dst_in == CPRS_DST_B || wr_dst_in == CPRS_DST_D)
        acc_b <= wr_data_in[7:0];  // RL1
      if (wr_dst_in == CPRS_DST_X)
        index_x <= wr_data_in[15:0];
      else if (ptr_upd && ix_base_in == CPRS_BASE_X)
        index_x <= next_ptr;
      if (wr_dst_in == CPRS_DST_Y)
        index_y <= wr_data_in[15:0];
      else if (ptr_upd && ix_base_in == CPRS_BASE_Y)
        index_y <= next_ptr;
      if (wr_dst_in == CPRS_DST_E)
        ext <= wr_data_in;  // RL14
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stack_top_pointer        <= `CPRS_SP_RESET;
      pc                       <= `CPRS_PC_RESET;
      condition_flags_register <= `CPRS_CCR_RESET;
    end
    else
    begin
      stack_top_pointer <= next_sp;
      if (pc_load_in)
        pc <= pc_target_in;  // RL6
      else
        pc <= pc + 16'(pc_advance_in);  // RL6
      if (ccr_we_in)
        condition_flags_register <= ccr_data_in;  // RL8
      else if (flags_we_in)
        condition_flags_register <= {condition_flags_register[7:6], flags_hnzvc_in[4],
                                     condition_flags_register[4], flags_hnzvc_in[3:0]};  // RL8
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Word access as two byte cycles, high byte first at the lower address
  assign word_wdata = push_word_in ? word_in : word_in;
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state             <= CPRS_ST_IDLE;
      word_addr         <= 16'h0000;
      word_wr           <= 1'b0;
      word_hi           <= 8'h00;
      mem_req_out       <= 1'b0;
      mem_wr_out        <= 1'b0;
      mem_addr_out      <= 16'h0000;
      mem_wdata_out     <= 8'h00;
      mem_word_out      <= 16'h0000;
      mem_word_done_out <= 1'b0;
    end
    else
    begin
      mem_word_done_out <= 1'b0;
      mem_req_out       <= 1'b0;
      unique case (state)
        CPRS_ST_IDLE:
        begin
          if (push_word_in)
          begin
            word_addr     <= sp_push;
            word_wr       <= 1'b1;
            word_hi       <= word_wdata[7:0];
            mem_req_out   <= 1'b1;
            mem_wr_out    <= 1'b1;
            mem_addr_out  <= sp_push;
            mem_wdata_out <= word_wdata[15:8];  // RL10
            state         <= CPRS_ST_HI;
          end
          else if (mem_word_start_in)
          begin
            // Any address, odd included, no fault
            word_addr     <= mem_addr_in;  // RL11
            word_wr       <= mem_we_in;
            word_hi       <= word_in[7:0];
            mem_req_out   <= 1'b1;
            mem_wr_out    <= mem_we_in;
            mem_addr_out  <= mem_addr_in;
            mem_wdata_out <= word_in[15:8];  // RL10
            state         <= CPRS_ST_HI;
          end
          else if (mem_byte_in)
          begin
            mem_req_out   <= 1'b1;
            mem_wr_out    <= mem_we_in;
            mem_addr_out  <= mem_addr_in;  // RL12
            mem_wdata_out <= word_in[7:0];  // RL12
          end
        end
        CPRS_ST_HI:
        begin
          if (!word_wr)
            mem_word_out[15:8] <= mem_rdata_in;  // RL10
          mem_req_out   <= 1'b1;
          mem_wr_out    <= word_wr;
          mem_addr_out  <= word_addr + 16'h0001;  // RL11
          mem_wdata_out <= word_hi;
          state         <= CPRS_ST_LO;
        end
        CPRS_ST_LO:
        begin
          if (!word_wr)
            mem_word_out[7:0] <= mem_rdata_in;
          mem_word_done_out <= 1'b1;
          state             <= CPRS_ST_IDLE;
        end
        default:
          state <= CPRS_ST_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  assign flush = pc_load_in;
  cprs_prefetch_q u_q (
    .mclk_in        (mclk_in),
    .nrst_in        (nrst_in),
    .flush_in       (flush),
    .push_in        (code_valid_in),
    .push_byte_in   (code_byte_in),
    .pop_count_in   (code_used_in),
    .head_bytes_out (q_head),
    .level_out      (q_level)
  );
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      acc_a_out                    <= 8'h00;
      acc_b_out                    <= 8'h00;
      acc_d_out                    <= 16'h0000;
      index_x_out                  <= 16'h0000;
      index_y_out                  <= 16'h0000;
      stack_top_pointer_out        <= `CPRS_SP_RESET;
      pc_out                       <= `CPRS_PC_RESET;
      condition_flags_register_out <= `CPRS_CCR_RESET;
      ext_out                      <= 20'h00000;
      ea_out                       <= 16'h0000;
      ix_illegal_out               <= 1'b0;
      br_take_out                  <= 1'b0;
      instr_ready_out              <= 1'b0;
      instr_bytes_out              <= 24'h000000;
    end
    else
    begin
      acc_a_out                    <= acc_a;
      acc_b_out                    <= acc_b;
      acc_d_out                    <= {acc_a, acc_b};  // RL2
      index_x_out                  <= index_x;
      index_y_out                  <= index_y;
      stack_top_pointer_out        <= stack_top_pointer;
      pc_out                       <= pc;
      condition_flags_register_out <= condition_flags_register;
      ext_out                      <= ext;
      ea_out                       <= ea;
      ix_illegal_out               <= ix_illegal;
      br_take_out                  <= br_take;
      instr_ready_out              <= (q_level >= 3'(`CPRS_QUEUE_MIN));  // RL13
      instr_bytes_out              <= q_head;
    end
  end
endmodule : cprs_core_regs

// ===== rtl/cprs_params.svh
// Register-set constants: reset values, field positions and widths
`ifndef CPRS_PARAMS_SVH
`define CPRS_PARAMS_SVH
`define CPRS_PC_RESET      16'h0000
`define CPRS_SP_RESET      16'h0000
`define CPRS_CCR_RESET     8'hd0
`define CPRS_CCR_C         0
`define CPRS_CCR_V         1
`define CPRS_CCR_Z         2
`define CPRS_CCR_N         3
`define CPRS_CCR_I         4
`define CPRS_CCR_H         5
`define CPRS_CCR_X         6
`define CPRS_CCR_S         7
`define CPRS_QUEUE_DEPTH   4
`define CPRS_QUEUE_MIN     3
`define CPRS_EXT_WIDTH     20
`endif

// ===== rtl/cprs_pkg.sv
// Types shared by the register-set files
package cprs_pkg;
  typedef enum logic [2:0] {
    CPRS_DST_NONE = 3'h0,
    CPRS_DST_A    = 3'h1,
    CPRS_DST_B    = 3'h2,
    CPRS_DST_D    = 3'h3,
    CPRS_DST_X    = 3'h4,
    CPRS_DST_Y    = 3'h5,
    CPRS_DST_SP   = 3'h6,
    CPRS_DST_E    = 3'h7
  } cprs_dst_t;
  typedef enum logic [2:0] {
    CPRS_IX_K5   = 3'h0,
    CPRS_IX_K9   = 3'h1,
    CPRS_IX_K16  = 3'h2,
    CPRS_IX_ACCA = 3'h3,
    CPRS_IX_ACCB = 3'h4,
    CPRS_IX_ACCD = 3'h5,
    CPRS_IX_AUTO = 3'h6
  } cprs_ixmode_t;
  typedef enum logic [1:0] {
    CPRS_BASE_X  = 2'h0,
    CPRS_BASE_Y  = 2'h1,
    CPRS_BASE_SP = 2'h2,
    CPRS_BASE_PC = 2'h3
  } cprs_base_t;
  typedef enum logic [2:0] {
    CPRS_ST_IDLE = 3'b001,
    CPRS_ST_HI   = 3'b010,
    CPRS_ST_LO   = 3'b100
  } cprs_state_t;
endpackage : cprs_pkg

// ===== rtl/cprs_prefetch_q.sv
// Instruction byte queue holding the next program bytes
`timescale 1ns/1ps
`include "cprs_params.svh"
module cprs_prefetch_q
  import cprs_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  // Fill side
  input  wire logic       flush_in,
  input  wire logic       push_in,
  input  wire logic [7:0] push_byte_in,
  // Drain side
  input  wire logic [1:0] pop_count_in,
  output logic [23:0]     head_bytes_out,
  output logic [2:0]      level_out
);
  logic [7:0] q [`CPRS_QUEUE_DEPTH];
  logic [2:0] level;
  logic [2:0] after_pop;
  logic [2:0] next_level;
  logic       do_push;
  assign after_pop  = (level > 3'(pop_count_in)) ? level - 3'(pop_count_in) : 3'h0;
  assign do_push    = push_in && (after_pop < 3'(`CPRS_QUEUE_DEPTH));
  assign next_level = after_pop + 3'(do_push);
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      level <= 3'h0;
      for (int i = 0; i < `CPRS_QUEUE_DEPTH; i++)
        q[i] <= 8'h00;
    end
    else if (flush_in)
      level <= 3'h0;
    else
    begin
      for (int i = 0; i < `CPRS_QUEUE_DEPTH; i++)
      begin
        if (do_push && (3'(i) == after_pop))
          q[i] <= push_byte_in;
        else if (i + int'(pop_count_in) < `CPRS_QUEUE_DEPTH)
          q[i] <= q[i + int'(pop_count_in)];
      end
      level <= next_level;
    end
  end
  // Registered view of head for timing
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      head_bytes_out <= 24'h000000;
      level_out      <= 3'h0;
    end
    else
    begin
      head_bytes_out <= {q[0], q[1], q[2]};
      level_out      <= level;
    end
  end
endmodule : cprs_prefetch_q

// ===== rtl/cprs_ea_unit.sv
// Indexed effective-address adder with base and mode checks
`timescale 1ns/1ps
`include "cprs_params.svh"
module cprs_ea_unit
  import cprs_pkg::*;
(
  // Operands
  input  wire logic [15:0]  base_in,
  input  wire cprs_base_t   base_sel_in,
  input  wire cprs_ixmode_t mode_in,
  input  wire logic [15:0]  const_in,
  input  wire logic [7:0]   acc_a_in,
  input  wire logic [7:0]   acc_b_in,
  // Result
  output logic [15:0]       ea_out,
  output logic              illegal_out
);
  logic [15:0] offset;
  always_comb
  begin
    unique case (mode_in)
      CPRS_IX_K5:   offset = {{11{const_in[4]}}, const_in[4:0]};
      CPRS_IX_K9:   offset = {{7{const_in[8]}}, const_in[8:0]};
      CPRS_IX_K16:  offset = const_in;
      CPRS_IX_ACCA: offset = {8'h00, acc_a_in};
      CPRS_IX_ACCB: offset = {8'h00, acc_b_in};
      CPRS_IX_ACCD: offset = {acc_a_in, acc_b_in};
      CPRS_IX_AUTO: offset = {{13{const_in[3]}}, const_in[2:0]} + 16'h0001;
      default:      offset = 16'h0000;
    endcase
  end
  assign ea_out      = base_in + offset;  // RL3
  assign illegal_out = (mode_in == CPRS_IX_AUTO) && (base_sel_in == CPRS_BASE_PC);  // RL7
endmodule : cprs_ea_unit

// ===== tb/cprs_core_regs_properties.sv
// Concurrent checks on the core register-set ports
`timescale 1ns/1ps
module cprs_core_regs_checker
  import cprs_pkg::*;
(
  // Clock and reset
  input wire logic         mclk_in,
  input wire logic         nrst_in,
  // Watched requests
  input wire cprs_dst_t    wr_dst_in,
  input wire logic [19:0]  wr_data_in,
  input wire cprs_base_t   ix_base_in,
  input wire cprs_ixmode_t ix_mode_in,
  input wire logic [15:0]  ix_const_in,
  input wire logic         ix_update_in,
  input wire logic         pc_load_in,
  input wire logic         ccr_we_in,
  input wire logic [3:0]   br_cond_in,
  // Watched results
  input wire logic [7:0]   acc_a_out,
  input wire logic [7:0]   acc_b_out,
  input wire logic [15:0]  acc_d_out,
  input wire logic [15:0]  index_x_out,
  input wire logic [7:0]   condition_flags_register_out,
  input wire logic [15:0]  ea_out,
  input wire logic         ix_illegal_out,
  input wire logic         mem_req_out,
  input wire logic [15:0]  mem_addr_out,
  input wire logic         mem_word_done_out,
  input wire logic         br_take_out,
  input wire logic         instr_ready_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  ////////////////////////////////////////////////////////////////////////////
  acc_pair_a: assert property (acc_d_out == {acc_a_out, acc_b_out})
    else $error("double accumulator halves disagree");
  acc_half_a: assert property (wr_dst_in == CPRS_DST_A |-> ##2
    acc_d_out[15:8] == 8'($past(wr_data_in, 2))) else $error("double accumulator half stale");
  word_order_a: assert property (mem_word_done_out |-> $past(mem_req_out) &&
    $past(mem_req_out, 2) && $past(mem_addr_out) == $past(mem_addr_out, 2) + 16'h0001)
    else $error("word bytes not at consecutive addresses");
  done_pulse_a: assert property (mem_word_done_out |=> !mem_word_done_out)
    else $error("word done held too long");
  pc_auto_a: assert property ((ix_base_in == CPRS_BASE_PC &&
    ix_mode_in == CPRS_IX_AUTO) |=> ix_illegal_out) else $error("pc auto form accepted");
  legal_base_a: assert property (ix_mode_in != CPRS_IX_AUTO |=> !ix_illegal_out)
    else $error("non-auto form refused");
  // Previous-cycle writes to X would make the visible X stale
  ea_k16_a: assert property ((ix_mode_in == CPRS_IX_K16 && ix_base_in == CPRS_BASE_X &&
    $past(wr_dst_in) != CPRS_DST_X && !$past(ix_update_in))
    |=> ea_out == $past(index_x_out) + $past(ix_const_in)) else $error("indexed sum wrong");
  flush_ready_a: assert property (pc_load_in |-> ##[1:3] !instr_ready_out)
    else $error("queue ready after flush");
  br_always_a: assert property (br_cond_in[3:1] == 3'h0
    |=> br_take_out == !$past(br_cond_in[0])) else $error("always branch wrong");
  masks_hold_a: assert property ((!ccr_we_in && !$past(ccr_we_in) &&
    !$past(ccr_we_in, 2)) |-> $stable({condition_flags_register_out[7:6],
    condition_flags_register_out[4]})) else $error("mask bits changed");
endmodule : cprs_core_regs_checker

bind cprs_core_regs cprs_core_regs_checker u_checker (.*);

// ===== tb/cprs_core_regs_tb.sv
// Self-checking bench for the core register set
`timescale 1ns/1ps
module cprs_core_regs_tb
  import cprs_pkg::*;
;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  cprs_dst_t wr_dst_in = CPRS_DST_NONE;
  cprs_base_t ix_base_in = CPRS_BASE_X;
  cprs_ixmode_t ix_mode_in = CPRS_IX_K16;
  logic [19:0] wr_data_in = 20'h00000;
  logic flags_we_in = 0, ccr_we_in = 0, pc_load_in = 0, ix_update_in = 0, push_word_in = 0;
  logic pull_word_in = 0, mem_word_start_in = 0, mem_byte_in = 0, mem_we_in = 0;
  logic code_valid_in = 0;
  logic [4:0] flags_hnzvc_in = 5'h00;
  logic [7:0] ccr_data_in = 8'h00, mem_rdata_in = 8'h00, code_byte_in = 8'h00;
  logic [15:0] pc_target_in = 0, ix_const_in = 0, word_in = 0, mem_addr_in = 0;
  logic [1:0] pc_advance_in = 2'h0, code_used_in = 2'h0;
  logic [3:0] br_cond_in = 4'h0;
  logic [7:0] acc_a_out, acc_b_out, condition_flags_register_out, mem_wdata_out;
  logic [15:0] acc_d_out, index_x_out, index_y_out, stack_top_pointer_out, pc_out, ea_out;
  logic [15:0] mem_addr_out, mem_word_out;
  logic [19:0] ext_out;
  logic [23:0] instr_bytes_out;
  logic ix_illegal_out, mem_req_out, mem_wr_out, mem_word_done_out, br_take_out;
  logic instr_ready_out;
  int n_errors = 0;
  int checked = 0;

  cprs_core_regs dut (.*);

  always #25 mclk_in = ~mclk_in;
  // Memory answers from the address; idle data toggles so stale bytes never match
  always @(posedge mclk_in) #2 mem_rdata_in = mem_req_out ? mem_addr_out[7:0] ^ 8'h5a
                                                          : ~mem_rdata_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask : step

  task automatic wr(input cprs_dst_t dst, input logic [19:0] data);
    wr_dst_in = dst;
    wr_data_in = data;
    step(1);
    wr_dst_in = CPRS_DST_NONE;
    step(2);
  endtask : wr

  task automatic ea_case(input cprs_base_t b, input cprs_ixmode_t m, input logic [15:0] k,
                         input logic [15:0] exp, input logic ill);
    ix_base_in = b;
    ix_mode_in = m;
    ix_const_in = k;
    step(3);
    chk(ix_illegal_out, ill, "illegal flag");
    if (!ill)
      chk(ea_out, exp, "effective address");
  endtask : ea_case

  // Entered just after the edge that took the request
  task automatic word_seq(input logic [15:0] a, input logic [7:0] hi, input logic [7:0] lo,
                          input logic w);
    chk({mem_req_out, mem_wr_out, mem_addr_out}, {1'b1, w, a}, "high byte req");
    if (w)
      chk(mem_wdata_out, hi, "high byte data");
    step(1);
    chk({mem_req_out, mem_addr_out}, {1'b1, a + 16'h0001}, "low byte req");
    if (w)
      chk(mem_wdata_out, lo, "low byte data");
    step(1);
    chk(mem_word_done_out, 1'b1, "word done");
    if (!w)
      chk(mem_word_out, {hi, lo}, "word read");
  endtask : word_seq

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(condition_flags_register_out, 8'hd0, "flags reset");
    chk({acc_d_out, pc_out}, 32'h0, "acc pc reset");
    chk(stack_top_pointer_out, 16'h0000, "stack reset");
  endtask : t_reset

  task automatic t_accs();
    wr(CPRS_DST_D, 20'h01234);
    chk({acc_a_out, acc_b_out, acc_d_out}, 32'h12341234, "double write");
    wr(CPRS_DST_A, 20'h000ab);
    chk({acc_a_out, acc_d_out}, 24'hab_ab34, "acc a write");
    wr(CPRS_DST_E, 20'habcde);
    chk(ext_out, 20'habcde, "extended reg");
  endtask : t_accs

  task automatic t_index();
    wr(CPRS_DST_X, 20'h01000);
    ea_case(CPRS_BASE_X, CPRS_IX_K16, 16'h0234, 16'h1234, 0);
    ea_case(CPRS_BASE_X, CPRS_IX_ACCA, 16'h0000, 16'h10ab, 0);
    ea_case(CPRS_BASE_X, CPRS_IX_ACCB, 16'h0000, 16'h1034, 0);
    ea_case(CPRS_BASE_X, CPRS_IX_ACCD, 16'h0000, 16'hbb34, 0);
    ea_case(CPRS_BASE_Y, CPRS_IX_K9, 16'hff00, 16'hff00, 0);
    ea_case(CPRS_BASE_PC, CPRS_IX_K5, 16'hfff0, 16'hfff0, 0);
    ea_case(CPRS_BASE_PC, CPRS_IX_AUTO, 16'h0003, 16'h0000, 1);
    ix_base_in = CPRS_BASE_X;
    ix_update_in = 1;
    step(1);
    ix_update_in = 0;
    ix_mode_in = CPRS_IX_K16;
    step(3);
    chk(index_x_out, 16'h1004, "auto step of four");
    wr(CPRS_DST_Y, 20'h0abcd);
    chk(index_y_out, 16'habcd, "index y write");
  endtask : t_index

  task automatic t_stack();
    wr(CPRS_DST_SP, 20'h01000);
    push_word_in = 1;
    word_in = 16'hbeef;
    step(1);
    push_word_in = 0;
    word_seq(16'h0ffe, 8'hbe, 8'hef, 1);
    step(2);
    chk(stack_top_pointer_out, 16'h0ffe, "sp after push");
    pull_word_in = 1;
    step(1);
    pull_word_in = 0;
    step(3);
    chk(stack_top_pointer_out, 16'h1000, "sp after pull");
    mem_word_start_in = 1;
    mem_addr_in = 16'h1fff;
    step(1);
    mem_word_start_in = 0;
    word_seq(16'h1fff, 8'ha5, 8'h5a, 0);
    mem_byte_in = 1;
    mem_we_in = 1;
    mem_addr_in = 16'h2003;
    word_in = 16'h00a7;
    step(1);
    mem_byte_in = 0;
    mem_we_in = 0;
    chk({mem_req_out, mem_wr_out, mem_addr_out, mem_wdata_out}, 26'h3_2003_a7, "byte");
    step(1);
    chk(mem_req_out, 1'b0, "single byte req");
  endtask : t_stack

  task automatic t_queue();
    int i;
    for (i = 1; i <= 3; i++)
    begin
      code_valid_in = 1;
      code_byte_in = 8'(i * 8'h11);
      step(1);
    end
    code_valid_in = 0;
    for (i = 0; i < 6 && instr_ready_out !== 1'b1; i++)
      step(1);
    if (instr_ready_out !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: queue never ready", $time);
      finish_test();
    end
    chk(instr_bytes_out, 24'h112233, "queue head");
    code_used_in = 2'h1;
    step(1);
    code_used_in = 2'h0;
    step(2);
    chk({instr_ready_out, instr_bytes_out}, 32'h0_223300, "queue pop");
    pc_load_in = 1;
    pc_target_in = 16'h4000;
    step(1);
    pc_load_in = 0;
    step(3);
    chk({instr_ready_out, pc_out}, 17'h0_4000, "pc load flush");
    pc_advance_in = 2'h2;
    step(1);
    pc_advance_in = 2'h0;
    step(3);
    chk(pc_out, 16'h4002, "pc advance");
  endtask : t_queue

  task automatic t_flags();
    logic [7:0] take;
    int i;
    take = 8'hc9;
    flags_we_in = 1;
    flags_hnzvc_in = 5'b00100;
    step(1);
    flags_we_in = 0;
    step(3);
    chk(condition_flags_register_out, 8'hd4, "flag update");
    ccr_we_in = 1;
    ccr_data_in = 8'h2b;
    step(1);
    ccr_we_in = 0;
    step(3);
    chk(condition_flags_register_out, 8'h2b, "whole flags load");
    for (i = 0; i < 16; i++)
    begin
      br_cond_in = 4'(i);
      step(2);
      chk(br_take_out, take[i / 2] ^ i[0], "branch decision");
    end
    br_cond_in = 4'h0;
  endtask : t_flags

  initial
  begin
    step(6);
    nrst_in = 1;
    t_reset();
    t_accs();
    t_index();
    t_stack();
    t_queue();
    t_flags();
    finish_test();
  end
endmodule : cprs_core_regs_tb
